/* verilog/obcd_pkg.sv */
// constants, types and decode functions for the option byte decoder
package obcd_pkg;

	// ------------------------------------------------------------
	// option byte field layout
	// ------------------------------------------------------------
	localparam int OB0_PINOUT_BIT = 1;
	localparam int OB0_PROTECT_BIT = 0;
	localparam logic [7:0] OB0_RESERVED_MASK = 8'hFC;
	localparam int OB1_CLKSEC_BIT = 7;
	localparam int OB1_OSC_HI = 6;
	localparam int OB1_OSC_LO = 4;
	localparam int OB1_LOWV_HI = 3;
	localparam int OB1_LOWV_LO = 2;
	localparam int OB1_HALT_BIT = 1;
	localparam int OB1_WDMODE_BIT = 0;
	localparam logic [7:0] OB_ERASED = 8'hFF;
	localparam logic SEL_BYTE0 = 1'b0;
	localparam logic SEL_BYTE1 = 1'b1;

	// ------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------
	localparam logic [2:0] OSC_CODE_EXT_CLOCK = 3'h7;
	localparam logic [2:0] OSC_CODE_INT_RC = 3'h6;
	localparam logic [1:0] OSC_CODE_EXT_RC_HI = 2'h2;
	localparam logic [2:0] OSC_CODE_LOW_POWER = 3'h3;
	localparam logic [2:0] OSC_CODE_MED_POWER = 3'h2;
	localparam logic [2:0] OSC_CODE_MED_SPEED = 3'h1;
	localparam logic [2:0] OSC_CODE_HIGH_SPEED = 3'h0;
	localparam logic [1:0] LV_CODE_OFF = 2'h3;
	localparam logic [1:0] LV_CODE_HIGHEST = 2'h2;
	localparam logic [1:0] LV_CODE_MEDIUM = 2'h1;
	localparam logic [1:0] LV_CODE_LOWEST = 2'h0;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_LOAD = 3'h1,
		ST_RUN = 3'h2,
		ST_PROG = 3'h4
	} obcd_state_e;

	typedef enum logic [6:0] {
		OSC_EXT_CLOCK = 7'h01,
		OSC_INT_RC = 7'h02,
		OSC_EXT_RC = 7'h04,
		OSC_LOW_POWER_RESONATOR = 7'h08,
		OSC_MEDIUM_POWER_RESONATOR = 7'h10,
		OSC_MEDIUM_SPEED_RESONATOR = 7'h20,
		OSC_HIGH_SPEED_RESONATOR = 7'h40
	} obcd_osc_e;

	typedef enum logic [3:0] {
		LV_OFF = 4'h1,
		LV_HIGHEST = 4'h2,
		LV_MEDIUM = 4'h4,
		LV_LOWEST = 4'h8
	} obcd_lowv_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic pinout_large;
		logic readout_protect;
		logic clock_security_en;
		obcd_osc_e osc_select;
		obcd_lowv_e low_voltage_threshold_select;
		logic watchdog_halt_reset;
		logic watchdog_always_on;
	} obcd_cfg_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic sel;
		logic [7:0] wdata;
	} obcd_preq_s;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} obcd_pans_s;

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} obcd_sync_s;

	typedef struct packed {
		obcd_state_e st;
		logic [7:0] nv0;
		logic [7:0] nv1;
		obcd_cfg_s cfg;
		logic cfg_valid;
		obcd_pans_s ans;
		logic erase;
		logic halt_rst;
	} obcd_top_s;

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	function automatic obcd_osc_e osc_decode(input logic [2:0] code);
		obcd_osc_e r;
		if (code == OSC_CODE_EXT_CLOCK)
			r = OSC_EXT_CLOCK;
		else if (code == OSC_CODE_INT_RC)
			r = OSC_INT_RC;
		else if (code[2:1] == OSC_CODE_EXT_RC_HI)
			r = OSC_EXT_RC;
		else if (code == OSC_CODE_LOW_POWER)
			r = OSC_LOW_POWER_RESONATOR;
		else if (code == OSC_CODE_MED_POWER)
			r = OSC_MEDIUM_POWER_RESONATOR;
		else if (code == OSC_CODE_MED_SPEED)
			r = OSC_MEDIUM_SPEED_RESONATOR;
		else
			r = OSC_HIGH_SPEED_RESONATOR;
		return r;
	endfunction

	function automatic obcd_lowv_e lowv_decode(input logic [1:0] code);
		obcd_lowv_e r;
		unique case (code)
			LV_CODE_OFF: r = LV_OFF;
			LV_CODE_HIGHEST: r = LV_HIGHEST;
			LV_CODE_MEDIUM: r = LV_MEDIUM;
			LV_CODE_LOWEST: r = LV_LOWEST;
		endcase
		return r;
	endfunction

	function automatic obcd_cfg_s cfg_decode(input logic [7:0] b0,
		input logic [7:0] b1);
		obcd_cfg_s c;
		c.pinout_large = b0[OB0_PINOUT_BIT];
		c.readout_protect = b0[OB0_PROTECT_BIT];
		c.clock_security_en = ~b1[OB1_CLKSEC_BIT];
		c.osc_select = osc_decode(b1[OB1_OSC_HI:OB1_OSC_LO]);
		c.low_voltage_threshold_select =
			lowv_decode(b1[OB1_LOWV_HI:OB1_LOWV_LO]);
		c.watchdog_halt_reset = b1[OB1_HALT_BIT];
		c.watchdog_always_on = ~b1[OB1_WDMODE_BIT];
		return c;
	endfunction

	localparam obcd_cfg_s CFG_ERASED = cfg_decode(OB_ERASED, OB_ERASED);

endpackage

/* verilog/obcd_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module obcd_sync
	import obcd_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic PIN,
	output logic LEVEL
);

	obcd_sync_s q;
	obcd_sync_s d;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// ff1 feeds ff2 only; the filter looks at ff2 and ff3
	always_comb
	begin
		d = q;
		d.ff1 = PIN;
		d.ff2 = q.ff1;
		d.ff3 = q.ff2;
		if (q.ff2 == q.ff3)
			d.level = q.ff3;
	end

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			q <= '0;
		else if (CE)
			q <= d;
	end

	assign LEVEL = q.level;

endmodule

/* verilog/obcd_top.sv */
// option byte store, programming access and configuration decode
`timescale 1ns/1ns
//
// Contract
// - byte0 bit1 picks small or large pinout
// - byte0 bit0 set blocks external program reads
// - clearing protect erases program memory, not options
// - flash parts never protect data eeprom
// - byte1 bit7 low enables clock security
// - byte1 bits6:4 choose main oscillator
// - byte1 bits3:2 set low-voltage detector threshold
// - byte1 bit1 resets on halt with watchdog
// - byte1 bit0 low forces hardware watchdog
// - option bytes reachable only in programming mode
// - unprogrammed option bytes read as FF
// - mask-rom parts use fixed option values
module obcd_top
	import obcd_pkg::*;
#(
	parameter logic MASK_ROM = 1'b0,
	parameter logic [7:0] ROM_BYTE0 = 8'hFF,
	parameter logic [7:0] ROM_BYTE1 = 8'hFF,
	parameter logic ROM_EEPROM_PROTECT = 1'b0
)
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic CHIP_RESET,
	input wire logic PROG_MODE_PIN,
	input wire obcd_preq_s PROG_REQ,
	output obcd_pans_s PROG_ANS,
	input wire logic HALT_ENTRY,
	input wire logic WATCHDOG_ACTIVE,
	output obcd_cfg_s CFG,
	output logic CFG_VALID,
	output logic PROG_MODE_ACTIVE,
	output logic PMEM_READ_BLOCK,
	output logic EEPROM_READ_BLOCK,
	output logic PMEM_ERASE_REQ,
	output logic HALT_RESET_REQ
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	obcd_top_s q;
	obcd_top_s d;
	logic prog_mode;
	logic [7:0] byte0_eff;
	logic [7:0] byte1_eff;
	logic prog_access;
	logic clears_protect;
	logic prog_taken;

	// ------------------------------------------------------------
	// programming mode pin
	// ------------------------------------------------------------
	obcd_sync u_prog_sync (
		.CLOCK(CLOCK),
		.RESET(RESET),
		.CE(CE),
		.PIN(PROG_MODE_PIN),
		.LEVEL(prog_mode)
	);

	// ------------------------------------------------------------
	// effective option contents
	// ------------------------------------------------------------
	// mask parts take the factory values; the stored cells are unused
	assign byte0_eff = MASK_ROM ? ROM_BYTE0 : q.nv0;
	assign byte1_eff = MASK_ROM ? ROM_BYTE1 : q.nv1;

	// outside programming mode there is no path to the cells at all
	assign prog_access = (q.st == ST_PROG) && !CHIP_RESET;
	assign prog_taken = prog_access && (PROG_REQ.wr || PROG_REQ.rd);

	// only a real 1 -> 0 transition of the protect bit erases
	assign clears_protect = prog_access && PROG_REQ.wr && !MASK_ROM
		&& (PROG_REQ.sel == SEL_BYTE0)
		&& q.nv0[OB0_PROTECT_BIT]
		&& !PROG_REQ.wdata[OB0_PROTECT_BIT];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.ans.ack = 1'b0;
		d.erase = 1'b0;
		d.halt_rst = 1'b0;
		unique case (q.st)
			ST_LOAD:
			begin
				// keep sampling the cells for as long as reset lasts
				d.cfg = cfg_decode(byte0_eff, byte1_eff);
				d.cfg_valid = 1'b0;
				if (!CHIP_RESET)
				begin
					d.cfg_valid = 1'b1;
					d.st = prog_mode ? ST_PROG : ST_RUN;
				end
			end
			// settings are void from the edge that sees the device reset
			ST_RUN:
			begin
				if (CHIP_RESET)
				begin
					d.st = ST_LOAD;
					d.cfg_valid = 1'b0;
				end
				else if (prog_mode)
					d.st = ST_PROG;
			end
			ST_PROG:
			begin
				if (CHIP_RESET)
				begin
					d.st = ST_LOAD;
					d.cfg_valid = 1'b0;
				end
				else if (!prog_mode)
					d.st = ST_RUN;
			end
		endcase

		if (prog_access && PROG_REQ.wr)
		begin
			d.ans.ack = 1'b1;
			if (!MASK_ROM)
			begin
				if (PROG_REQ.sel == SEL_BYTE1)
					d.nv1 = PROG_REQ.wdata;
				else
					// a stray zero in a reserved bit is not kept
					d.nv0 = PROG_REQ.wdata | OB0_RESERVED_MASK;
			end
			// the option cells themselves are never part of the erase
			d.erase = clears_protect;
		end
		else if (prog_access && PROG_REQ.rd)
		begin
			d.ans.ack = 1'b1;
			d.ans.rdata = (PROG_REQ.sel == SEL_BYTE1) ? byte1_eff
				: byte0_eff;
		end

		// halt reset only once the configuration is in force
		if (q.st != ST_LOAD)
			d.halt_rst = HALT_ENTRY && WATCHDOG_ACTIVE
				&& q.cfg.watchdog_halt_reset;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// cells start erased; RESET here stands for first power-up only
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			q.st <= ST_LOAD;
			q.nv0 <= OB_ERASED;
			q.nv1 <= OB_ERASED;
			q.cfg <= CFG_ERASED;
			q.cfg_valid <= 1'b0;
			q.ans <= '0;
			q.erase <= 1'b0;
			q.halt_rst <= 1'b0;
		end
		else if (CE)
			q <= d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign CFG = q.cfg;
	assign CFG_VALID = q.cfg_valid;
	assign PROG_MODE_ACTIVE = (q.st == ST_PROG);
	assign PROG_ANS = q.ans;
	assign PMEM_READ_BLOCK = q.cfg.readout_protect;
	// the protect bit has no say over the data eeprom on flash parts
	assign EEPROM_READ_BLOCK = MASK_ROM & ROM_EEPROM_PROTECT;
	assign PMEM_ERASE_REQ = q.erase;
	assign HALT_RESET_REQ = q.halt_rst;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	sequence load_exit;
		CE && q.st == ST_LOAD && !CHIP_RESET;
	endsequence

	sequence protect_clear_write;
		CE && clears_protect;
	endsequence

	sequence erase_pulse;
		PMEM_ERASE_REQ ##1 (!PMEM_ERASE_REQ || !$past(CE));
	endsequence

	AST_PINOUT_LATCH: assert property (load_exit |=>
		CFG.pinout_large == $past(byte0_eff[OB0_PINOUT_BIT]))
		else $error("pinout setting not taken from byte0 bit1");

	AST_PROTECT_BLOCK: assert property (load_exit |=>
		PMEM_READ_BLOCK == $past(byte0_eff[OB0_PROTECT_BIT]))
		else $error("program read block does not follow protect bit");

	AST_ERASE_ON_CLEAR: assert property (
		protect_clear_write |=> erase_pulse)
		else $error("protect clear did not give one erase pulse");

	AST_ERASE_CAUSE: assert property (
		PMEM_ERASE_REQ
		|-> (!$past(CE) || $past(clears_protect)) && !MASK_ROM)
		else $error("erase pulse without a protect clear");

	AST_EEPROM_OPEN: assert property (
		!MASK_ROM |-> !EEPROM_READ_BLOCK)
		else $error("flash part blocks data eeprom reads");

	AST_CLOCK_SECURITY: assert property (load_exit |=>
		CFG.clock_security_en == !$past(byte1_eff[OB1_CLKSEC_BIT]))
		else $error("clock security enable has wrong polarity");

	AST_OSC_SELECT: assert property (load_exit |=>
		CFG.osc_select == osc_decode($past(byte1_eff[OB1_OSC_HI:OB1_OSC_LO])))
		else $error("oscillator selection decoded wrongly");

	AST_OSC_EXT_RC: assert property (
		(load_exit and
		(byte1_eff[OB1_OSC_HI:OB1_OSC_HI-1] == OSC_CODE_EXT_RC_HI))
		|=> CFG.osc_select == OSC_EXT_RC)
		else $error("codes 10x do not select the external rc");

	AST_LOWV_SELECT: assert property (load_exit |=>
		CFG.low_voltage_threshold_select
		== lowv_decode($past(byte1_eff[OB1_LOWV_HI:OB1_LOWV_LO])))
		else $error("low-voltage threshold decoded wrongly");

	AST_HALT_RESET: assert property (
		CE && q.st != ST_LOAD && HALT_ENTRY && WATCHDOG_ACTIVE
		|=> HALT_RESET_REQ == $past(CFG.watchdog_halt_reset))
		else $error("halt reset does not follow the halt option");

	AST_HALT_QUIET: assert property (
		HALT_RESET_REQ
		|-> !$past(CE) || ($past(WATCHDOG_ACTIVE) && $past(HALT_ENTRY)))
		else $error("halt reset without halt entry under watchdog");

	AST_WATCHDOG_MODE: assert property (load_exit |=>
		CFG.watchdog_always_on == !$past(byte1_eff[OB1_WDMODE_BIT]))
		else $error("watchdog type decoded wrongly");

	AST_NO_ACCESS_OUTSIDE_PROG: assert property (
		CE && q.st != ST_PROG && (PROG_REQ.wr || PROG_REQ.rd)
		|=> !PROG_ANS.ack && $stable(q.nv0) && $stable(q.nv1))
		else $error("option bytes reached outside programming mode");

	AST_PROG_ACK: assert property (
		CE && prog_taken
		|=> PROG_ANS.ack ##1 (!PROG_ANS.ack || !$past(CE)
		|| $past(prog_taken)))
		else $error("programming access not answered next cycle");

	AST_FIXED_ROM: assert property (
		MASK_ROM |-> byte0_eff == ROM_BYTE0 && byte1_eff == ROM_BYTE1)
		else $error("mask part does not use fixed option values");

	AST_RESERVED_ONES: assert property (
		(q.nv0 & OB0_RESERVED_MASK) == OB0_RESERVED_MASK)
		else $error("reserved bits of byte0 stored as zero");

	AST_HELD_AFTER_LOAD: assert property (
		q.st != ST_LOAD |=> $stable(CFG))
		else $error("configuration changed outside reset");

	// a device reset voids the settings on the edge that sees it
	AST_VALID_DROP: assert property (
		CE && q.st != ST_LOAD && CHIP_RESET
		|=> !CFG_VALID && q.st == ST_LOAD)
		else $error("settings still valid during device reset");

	AST_VALID_SET: assert property (
		load_exit |=> CFG_VALID && q.st != ST_LOAD)
		else $error("settings not valid after leaving load");

	// a low enable must hold every register, answers included
	AST_FREEZE: assert property (
		!CE |=> $stable(q))
		else $error("state moved while the clock enable was low");

	AST_STORE_BYTE1: assert property (
		CE && prog_access && PROG_REQ.wr && PROG_REQ.sel == SEL_BYTE1
		&& !MASK_ROM |=> q.nv1 == $past(PROG_REQ.wdata))
		else $error("byte1 write not stored in programming mode");

	AST_OPTIONS_KEPT: assert property (
		PMEM_ERASE_REQ |-> $stable(q.nv1) && !q.nv0[OB0_PROTECT_BIT])
		else $error("erase touched the option cells");

endmodule

/* tb/obcd_tool.sv */
// programming tool model that drives the option byte access port
`timescale 1ns/1ns
module obcd_tool
	import obcd_pkg::*;
(
	input wire logic CLOCK,
	input wire logic PROG_MODE_ACTIVE,
	input wire obcd_pans_s PROG_ANS,
	output obcd_preq_s PROG_REQ
);
	initial
	begin
		PROG_REQ = '0;
	end

	// ------------------------------------------------------------
	// one request per call; rogue skips the programming-mode wait
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic sel,
		input logic [7:0] d, input logic rogue,
		output logic ack, output logic [7:0] q);
		int n;
		n = 0;
		while (!rogue && PROG_MODE_ACTIVE !== 1'b1 && n < 20)
		begin
			@(negedge CLOCK);
			n++;
		end
		@(negedge CLOCK);
		PROG_REQ.wr = w;
		PROG_REQ.rd = ~w;
		PROG_REQ.sel = sel;
		PROG_REQ.wdata = d;
		if (w && sel == SEL_BYTE0)
			PROG_REQ.wdata = d | OB0_RESERVED_MASK;
		@(negedge CLOCK);
		ack = PROG_ANS.ack;
		q = PROG_ANS.rdata;
		// released data lines must not keep their last value
		PROG_REQ.wr = 1'b0;
		PROG_REQ.rd = 1'b0;
		PROG_REQ.wdata = ~PROG_REQ.wdata;
	endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the option byte decoder
`timescale 1ns/1ns
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module testbench
	import obcd_pkg::*;
;
	logic clock, reset, chip_reset, prog_pin, halt_entry, wd_active;
	logic ack;
	logic [7:0] q, last_b1;
	int n_fail, n_compared;
	obcd_preq_s preq;
	obcd_pans_s pans;
	obcd_cfg_s cfg, rom_cfg;
	logic cfg_valid, prog_act, pblock, eblock, erase, halt_rst, rom_eblock;
	logic ce, rom_pblock, rom_halt;
	obcd_pans_s rom_pans;
	localparam obcd_osc_e OSC_T [8] = '{OSC_HIGH_SPEED_RESONATOR,
		OSC_MEDIUM_SPEED_RESONATOR, OSC_MEDIUM_POWER_RESONATOR,
		OSC_LOW_POWER_RESONATOR, OSC_EXT_RC, OSC_EXT_RC, OSC_INT_RC,
		OSC_EXT_CLOCK};
	localparam obcd_lowv_e LV_T [4] = '{LV_LOWEST, LV_MEDIUM, LV_HIGHEST,
		LV_OFF};

	obcd_top u_dut (.CLOCK(clock), .RESET(reset), .CE(ce),
		.CHIP_RESET(chip_reset), .PROG_MODE_PIN(prog_pin), .PROG_REQ(preq),
		.PROG_ANS(pans), .HALT_ENTRY(halt_entry),
		.WATCHDOG_ACTIVE(wd_active), .CFG(cfg), .CFG_VALID(cfg_valid),
		.PROG_MODE_ACTIVE(prog_act), .PMEM_READ_BLOCK(pblock),
		.EEPROM_READ_BLOCK(eblock), .PMEM_ERASE_REQ(erase),
		.HALT_RESET_REQ(halt_rst));
	obcd_top #(.MASK_ROM(1'b1), .ROM_BYTE0(8'hFD), .ROM_BYTE1(8'h2A),
		.ROM_EEPROM_PROTECT(1'b1)) u_rom (.CLOCK(clock), .RESET(reset),
		.CE(ce), .CHIP_RESET(chip_reset), .PROG_MODE_PIN(prog_pin),
		.PROG_REQ(preq), .PROG_ANS(rom_pans), .HALT_ENTRY(halt_entry),
		.WATCHDOG_ACTIVE(wd_active), .CFG(rom_cfg), .CFG_VALID(),
		.PROG_MODE_ACTIVE(), .PMEM_READ_BLOCK(rom_pblock),
		.EEPROM_READ_BLOCK(rom_eblock), .PMEM_ERASE_REQ(),
		.HALT_RESET_REQ(rom_halt));
	obcd_tool u_tool (.CLOCK(clock), .PROG_MODE_ACTIVE(prog_act),
		.PROG_ANS(pans), .PROG_REQ(preq));

	function automatic obcd_cfg_s exp_cfg(input logic [7:0] b0,
		input logic [7:0] b1);
		obcd_cfg_s c;
		c.pinout_large = b0[1];
		c.readout_protect = b0[0];
		c.clock_security_en = ~b1[7];
		c.osc_select = OSC_T[b1[6:4]];
		c.low_voltage_threshold_select = LV_T[b1[3:2]];
		c.watchdog_halt_reset = b1[1];
		c.watchdog_always_on = ~b1[0];
		return c;
	endfunction

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic prog_set(input logic v);
		int n;
		@(negedge clock);
		prog_pin = v;
		n = 0;
		while (prog_act !== v && n < 20)
		begin
			@(negedge clock);
			n++;
		end
		`CHK(prog_act, v)
	endtask

	task automatic chip_rst();
		@(negedge clock);
		chip_reset = 1'b1;
		@(negedge clock);
		chip_reset = 1'b0;
		`CHK(cfg_valid, 1'b0)
		@(negedge clock);
		`CHK(cfg_valid, 1'b1)
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_erased();
		`CHK(cfg, exp_cfg(8'hFF, 8'hFF))
		`CHK(eblock, 1'b0)
		`CHK(rom_cfg, exp_cfg(8'hFD, 8'h2A))
		`CHK(rom_eblock, 1'b1)
		prog_set(1'b1);
		u_tool.xfer(1'b0, SEL_BYTE0, 8'h00, 1'b0, ack, q);
		`CHK(q, OB_ERASED)
		`CHK(rom_pans, {1'b1, 8'hFD})
		u_tool.xfer(1'b0, SEL_BYTE1, 8'h00, 1'b0, ack, q);
		`CHK(q, OB_ERASED)
		$display("test erased done");
	endtask

	task automatic t_erase();
		u_tool.xfer(1'b1, SEL_BYTE0, 8'hFE, 1'b0, ack, q);
		`CHK({ack, erase}, 2'b11)
		`CHK(cfg.readout_protect, 1'b1)
		`CHK(pblock, 1'b1)
		`CHK(rom_pblock, 1'b1)
		u_tool.xfer(1'b1, SEL_BYTE0, 8'hFE, 1'b0, ack, q);
		`CHK(erase, 1'b0)
		u_tool.xfer(1'b0, SEL_BYTE0, 8'h00, 1'b0, ack, q);
		`CHK(q, 8'hFE)
		u_tool.xfer(1'b0, SEL_BYTE1, 8'h00, 1'b0, ack, q);
		`CHK(q, OB_ERASED)
		$display("test erase done");
	endtask

	task automatic t_decode();
		logic [7:0] b0, b1;
		for (int i = 0; i < 8; i++)
		begin
			b0 = {6'h3F, i[1], i[0]};
			b1 = {i[0], i[2:0], i[1:0], i[2], ~i[0]};
			wd_active = i[1];
			u_tool.xfer(1'b1, SEL_BYTE0, b0, 1'b0, ack, q);
			u_tool.xfer(1'b1, SEL_BYTE1, b1, 1'b0, ack, q);
			u_tool.xfer(1'b0, SEL_BYTE1, 8'h00, 1'b0, ack, q);
			`CHK({ack, q}, {1'b1, b1})
			chip_rst();
			`CHK(cfg, exp_cfg(b0, b1))
			`CHK(pblock, b0[0])
			`CHK(eblock, 1'b0)
			halt_entry = 1'b1;
			@(negedge clock);
			halt_entry = 1'b0;
			`CHK(halt_rst, b1[1] & i[1])
			`CHK(rom_halt, i[1])
			last_b1 = b1;
		end
		$display("test decode done");
	endtask

	task automatic t_refuse();
		prog_set(1'b0);
		u_tool.xfer(1'b1, SEL_BYTE1, 8'h00, 1'b1, ack, q);
		`CHK(ack, 1'b0)
		prog_set(1'b1);
		u_tool.xfer(1'b0, SEL_BYTE1, 8'h00, 1'b0, ack, q);
		`CHK(q, last_b1)
		chip_rst();
		`CHK(rom_cfg, exp_cfg(8'hFD, 8'h2A))
		$display("test refuse done");
	endtask

	// halt option is set here, so a leak through the enable shows
	task automatic t_freeze();
		@(negedge clock);
		ce = 1'b0;
		chip_reset = 1'b1;
		halt_entry = 1'b1;
		wd_active = 1'b1;
		repeat (3) @(negedge clock);
		chip_reset = 1'b0;
		halt_entry = 1'b0;
		`CHK({cfg_valid, prog_act, halt_rst}, 3'b110)
		ce = 1'b1;
		@(negedge clock);
		`CHK({cfg_valid, prog_act, halt_rst}, 3'b110)
		$display("test freeze done");
	endtask

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		#(8 * 5000);
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		n_fail = 0;
		n_compared = 0;
		reset = 1'b1;
		chip_reset = 1'b0;
		prog_pin = 1'b0;
		halt_entry = 1'b0;
		wd_active = 1'b0;
		last_b1 = 8'h00;
		ce = 1'b1;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		repeat (2) @(negedge clock);
		t_erased();
		t_erase();
		t_decode();
		t_refuse();
		t_freeze();
		report_and_stop();
	end
endmodule
